// [bench/gtu_pin_model.sv]
// external 32.768 khz pin clock source for the clock mode
`timescale 1ns/10ps
module gtu_pin_model #(
   parameter int HALF_NS = 15259
) (
   input wire logic en,
   output logic pin
);
   // toggles only while enabled; rests low so no stray edge is counted
   initial begin
      pin = 1'b0;
      forever begin
         #HALF_NS;
         pin = en ? ~pin : 1'b0;
      end
   end
endmodule

// [bench/test_dual_timer_32bit_rtc.sv]
// self-checking bench for the general timer unit
`timescale 1ns/10ps
module test_dual_timer_32bit_rtc;
   // ------------------------------------------------------------
   // signals and counters
   // ------------------------------------------------------------
   logic clk, nrst, psel, pen, pwr, rdy, ta, irq, pin_en, pin, err, tb, odd;
   logic [31:0] tbn = 32'h00000000;
   logic [11:0] pa;
   logic [31:0] pwd, prd, rnd;
   logic [31:0] exp_q[$];
   int errors = 0, check_count = 0, cyc = 0, n;
   gtu_timer #(.RTC_DIVIDE(4)) DUT (.SYS_CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(pen),
      .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(rdy), .PSLVERR(err),
      .CCP_EVEN(pin), .CCP_ODD(odd), .TRIG_A(ta), .TRIG_B(tb), .TIMER_IRQ(irq));
   gtu_pin_model PIN (.en(pin_en), .pin(pin));
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         errors++;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask
   // holds the request until pready is seen high at a rising edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (rdy !== 1'b1);
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task rd(input logic [11:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, 32'h00000000);
   endtask
   // bounded wait on the interrupt line or the trigger
   task wt(input logic s, input int lim);
      n = 0;
      while (((s ? irq : ta) !== 1'b1) && n < lim) begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask
   task test_done;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // read data is taken off the queue at the edge that completes a read
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         errors++;
         test_done();
      end
      if (psel && pen && !pwr && rdy === 1'b1)
         chk(prd, exp_q.pop_front());
      // only the one unmapped offset that the bench uses may answer with an error
      if (psel && pen && rdy === 1'b1)
         chk(err, {31'h0, pa == 12'h100});
      // trigger b pulses are counted so that a stuck-high pulse shows up
      tbn <= tbn + {31'h0, tb};
   end
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      {nrst, psel, pen, pwr, pin_en, odd} = '0;
      pa = '0;
      pwd = '0;
      rnd = 32'h00000016;
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      rd(gtu_pkg::OFS_A_COUNT, 32'hffffffff);
      rd(gtu_pkg::OFS_A_LOAD, 32'hffffffff);
      rd(gtu_pkg::OFS_A_PRESCALE, 32'h00000000);
      rd(gtu_pkg::OFS_B_PRESCALE, 32'h00000000);
      rd(12'h100, 32'h00000000);
      repeat (5) rnd = lfsr(rnd);
      apb(1'b1, gtu_pkg::OFS_A_LOAD, rnd);
      rd(gtu_pkg::OFS_A_COUNT, rnd);
      rd(gtu_pkg::OFS_B_LOAD, {16'h0000, rnd[31:16]});
      apb(1'b1, gtu_pkg::OFS_CONFIG, 32'h00000004);
      rd(gtu_pkg::OFS_CONFIG, 32'h00000004);
      apb(1'b1, gtu_pkg::OFS_CONFIG, 32'h00000000);
      // one-shot from 3 with the time-out unmasked only afterwards
      apb(1'b1, gtu_pkg::OFS_A_LOAD, 32'h00000003);
      apb(1'b1, gtu_pkg::OFS_A_MODE, 32'h00000001);
      apb(1'b1, gtu_pkg::OFS_B_MODE, 32'h00000002);
      apb(1'b1, gtu_pkg::OFS_CONTROL, 32'h00000021);
      wt(1'b0, 50);
      chk(ta, 1'b1);
      @(posedge clk);
      #1;
      chk(ta, 1'b0);
      rd(gtu_pkg::OFS_A_COUNT, 32'h00000003);
      rd(gtu_pkg::OFS_CONTROL, 32'h00000020);
      rd(gtu_pkg::OFS_RAW_STATUS, 32'h00000001);
      rd(gtu_pkg::OFS_MASKED_STATUS, 32'h00000000);
      chk(irq, 1'b0);
      apb(1'b1, gtu_pkg::OFS_INT_MASK, 32'h00000001);
      rd(gtu_pkg::OFS_MASKED_STATUS, 32'h00000001);
      chk(irq, 1'b1);
      apb(1'b1, gtu_pkg::OFS_INT_CLEAR, 32'h00000001);
      rd(gtu_pkg::OFS_RAW_STATUS, 32'h00000000);
      // stalled counter takes a new load and holds it
      apb(1'b1, gtu_pkg::OFS_A_MODE, 32'h00000002);
      apb(1'b1, gtu_pkg::OFS_CONTROL, 32'h00000003);
      apb(1'b1, gtu_pkg::OFS_A_LOAD, 32'h00000040);
      rd(gtu_pkg::OFS_A_COUNT, 32'h00000040);
      rd(gtu_pkg::OFS_A_COUNT, 32'h00000040);
      // released stall steps once before the read setup; a running load restarts the count
      apb(1'b1, gtu_pkg::OFS_CONTROL, 32'h00000001);
      rd(gtu_pkg::OFS_A_COUNT, 32'h0000003f);
      apb(1'b1, gtu_pkg::OFS_A_LOAD, 32'h00000040);
      rd(gtu_pkg::OFS_A_COUNT, 32'h0000003f);
      apb(1'b1, gtu_pkg::OFS_CONTROL, 32'h00000000);
      // split mode: timer b counts rises of the odd pin and pulses its trigger once
      apb(1'b1, gtu_pkg::OFS_CONFIG, 32'h00000004);
      apb(1'b1, gtu_pkg::OFS_B_LOAD, 32'h00000002);
      apb(1'b1, gtu_pkg::OFS_B_MODE, 32'h00000003);
      apb(1'b1, gtu_pkg::OFS_CONTROL, 32'h00002100);
      repeat (3) begin
         odd <= 1'b1;
         repeat (4) @(posedge clk);
         odd <= 1'b0;
         repeat (4) @(posedge clk);
      end
      chk(tbn, 32'h00000001);
      rd(gtu_pkg::OFS_B_COUNT, 32'h00000002);
      rd(gtu_pkg::OFS_RAW_STATUS, 32'h00000100);
      apb(1'b1, gtu_pkg::OFS_INT_CLEAR, 32'h00000100);
      // clock mode: starts at 1, counts up to match 2, rolls to 0
      apb(1'b1, gtu_pkg::OFS_CONFIG, 32'h00000001);
      rd(gtu_pkg::OFS_A_COUNT, 32'h00000001);
      apb(1'b1, gtu_pkg::OFS_A_MATCH, 32'h00000002);
      apb(1'b1, gtu_pkg::OFS_INT_MASK, 32'h00000008);
      apb(1'b1, gtu_pkg::OFS_CONTROL, 32'h00000013);
      pin_en <= 1'b1;
      wt(1'b1, 40000);
      chk(irq, 1'b1);
      rd(gtu_pkg::OFS_A_COUNT, 32'h00000000);
      rd(gtu_pkg::OFS_RAW_STATUS, 32'h00000008);
      apb(1'b1, gtu_pkg::OFS_INT_CLEAR, 32'h00000008);
      rd(gtu_pkg::OFS_MASKED_STATUS, 32'h00000000);
      pin_en <= 1'b0;
      test_done();
   end
endmodule

// [inc/gtu_pkg.sv]
// constants shared by the general timer unit files
package gtu_pkg;

   // ------------------------------------------------------------
   // register byte offsets on the apb bus
   // ------------------------------------------------------------
   localparam logic [11:0] OFS_CONFIG = 12'h000;
   localparam logic [11:0] OFS_A_MODE = 12'h004;
   localparam logic [11:0] OFS_B_MODE = 12'h008;
   localparam logic [11:0] OFS_CONTROL = 12'h00c;
   localparam logic [11:0] OFS_INT_MASK = 12'h018;
   localparam logic [11:0] OFS_RAW_STATUS = 12'h01c;
   localparam logic [11:0] OFS_MASKED_STATUS = 12'h020;
   localparam logic [11:0] OFS_INT_CLEAR = 12'h024;
   localparam logic [11:0] OFS_A_LOAD = 12'h028;
   localparam logic [11:0] OFS_B_LOAD = 12'h02c;
   localparam logic [11:0] OFS_A_MATCH = 12'h030;
   localparam logic [11:0] OFS_A_PRESCALE = 12'h038;
   localparam logic [11:0] OFS_B_PRESCALE = 12'h03c;
   localparam logic [11:0] OFS_A_COUNT = 12'h048;
   localparam logic [11:0] OFS_B_COUNT = 12'h04c;

   // ------------------------------------------------------------
   // configuration codes and mode field codes
   // ------------------------------------------------------------
   localparam logic [2:0] CFG_TIMER32 = 3'h0;
   localparam logic [2:0] CFG_RTC32 = 3'h1;
   localparam logic [2:0] CFG_SPLIT16 = 3'h4;
   localparam logic [1:0] MODE_ONE_SHOT = 2'h1;
   localparam logic [1:0] MODE_PERIODIC = 2'h2;
   localparam logic [1:0] MODE_EDGE_COUNT = 2'h3;

   // ------------------------------------------------------------
   // control, status and clear bit positions
   // ------------------------------------------------------------
   localparam int unsigned CTL_A_ENABLE = 0;
   localparam int unsigned CTL_A_STALL = 1;
   localparam int unsigned CTL_CLOCK_EN = 4;
   localparam int unsigned CTL_A_TRIG_EN = 5;
   localparam int unsigned CTL_B_ENABLE = 8;
   localparam int unsigned CTL_B_STALL = 9;
   localparam int unsigned CTL_B_TRIG_EN = 13;
   localparam logic [15:0] CTL_MASK = 16'h2333;
   localparam int unsigned INT_A_TIMEOUT = 0;
   localparam int unsigned INT_CLOCK_MATCH = 3;
   localparam int unsigned INT_B_TIMEOUT = 8;
   localparam logic [8:0] INT_MASK_BITS = 9'h109;

   // ------------------------------------------------------------
   // reset values and clock divide
   // ------------------------------------------------------------
   localparam logic [15:0] COUNT_RESET = 16'hffff;
   localparam logic [15:0] LOAD_RESET = 16'hffff;
   localparam logic [7:0] PRESCALE_RESET = 8'h00;
   localparam logic [31:0] MATCH_RESET = 32'hffffffff;
   localparam logic [31:0] RTC_START = 32'h00000001;
   localparam logic [31:0] RTC_ROLL = 32'h00000000;
   localparam int unsigned RTC_PIN_HZ = 32768;
   localparam int unsigned RTC_TICK_HZ = 1;
   localparam int unsigned RTC_DIV_DEFAULT = RTC_PIN_HZ / RTC_TICK_HZ;

endpackage

// [logic/gtu_pin_sync.sv]
// three-stage pin synchroniser with agreement filter and rise pulse
`timescale 1ns/10ps
module gtu_pin_sync (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic pin,
   output logic level,
   output logic rise
);

   logic stage1;
   logic stage2;
   logic stage3;

   // ------------------------------------------------------------
   // synchroniser chain; stage1 feeds only stage2
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stage1 <= 1'b0;
         stage2 <= 1'b0;
         stage3 <= 1'b0;
      end else begin
         stage1 <= pin;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // level changes only once stages two and three agree
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         level <= 1'b0;
      end else if (stage2 == stage3) begin
         level <= stage3;
      end
   end

   // one-cycle pulse on a filtered rising edge
   assign rise = (stage2 == stage3) && stage3 && !level;

endmodule

// [logic/gtu_timer.sv]
// general timer unit: two 16-bit counters, joinable into 32-bit timer or clock
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/10ps
// ------------------------------------------------------------
// How it works
// - two 16-bit counters, split or joined 32-bit
// - reset: counters and loads hold all ones
// - reset: both prescale registers hold zero
// - config 0 timer32, config 1 clock32
// - config 4 splits into two 16-bit timers
// - 32-bit uses even pin only, 16-bit both
// - joined load write fills upper and lower
// - joined count read: upper then lower half
// - 32-bit one-shot/periodic from lower mode only
// - enable starts countdown from preloaded value
// - zero reloads; one-shot stops, periodic continues
// - zero sets sticky time-out raw flag
// - unmasked time-out also sets masked flag
// - trigger pulses one cycle at zero
// - load write while running restarts from it
// - stall bit freezes the joined counter
// - clock mode counts upward
// - first clock selection loads one
// - 32.768 kHz pin divided to 1 Hz
// - clock match rolls counter to zero
// - match sets raw flag; masked flag and interrupt if unmasked
// - clock enable bit overrides both stall bits
// ------------------------------------------------------------
module gtu_timer #(
   parameter int unsigned RTC_DIVIDE = gtu_pkg::RTC_DIV_DEFAULT
) (
   input wire logic SYS_CLK,
   input wire logic NRST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic CCP_EVEN,
   input wire logic CCP_ODD,
   output logic TRIG_A,
   output logic TRIG_B,
   output logic TIMER_IRQ
);

   localparam logic [15:0] DIV_LAST = 16'(RTC_DIVIDE - 1);

   logic [2:0] timer_config;
   logic [1:0] mode_field [2];
   logic [15:0] timer_control;
   logic [15:0] interval_load [2];
   logic [15:0] count_val [2];
   logic [7:0] prescale [2];
   logic [31:0] match_value;
   logic [8:0] interrupt_mask;
   logic [8:0] raw_status;
   logic [8:0] masked_status;
   logic [15:0] div_count;
   logic [31:0] count32;
   logic [31:0] load32;
   logic [31:0] next_count32;
   logic [31:0] next_rdata;
   logic [1:0] pin_rise;
   logic [1:0] enable;
   logic [1:0] stall;
   logic [1:0] run16;
   logic [1:0] step16;
   logic [1:0] hit16;
   logic [1:0] one_shot_done;
   logic is32;
   logic is_rtc;
   logic run32;
   logic hit32;
   logic rtc_hold;
   logic sec_tick;
   logic rtc_step;
   logic rtc_hit;
   logic rtc_first;
   logic wr;
   logic rd_setup;
   logic addr_ok;
   logic wr_load_a;
   logic wr_load_b;

   // ------------------------------------------------------------
   // apb slave: zero wait states, error on unmapped offsets
   // ------------------------------------------------------------
   assign wr = PSEL && PENABLE && PWRITE && addr_ok;
   assign rd_setup = PSEL && !PENABLE && !PWRITE;
   assign PREADY = 1'b1;
   assign PSLVERR = PSEL && PENABLE && !addr_ok;
   assign wr_load_a = wr && (PADDR == gtu_pkg::OFS_A_LOAD);
   assign wr_load_b = wr && (PADDR == gtu_pkg::OFS_B_LOAD);

   // ------------------------------------------------------------
   // mode decode and joined views
   // ------------------------------------------------------------
   assign is32 = (timer_config != gtu_pkg::CFG_SPLIT16);
   assign is_rtc = (timer_config == gtu_pkg::CFG_RTC32);
   assign count32 = {count_val[1], count_val[0]};
   assign load32 = {interval_load[1], interval_load[0]};
   assign enable = {timer_control[gtu_pkg::CTL_B_ENABLE], timer_control[gtu_pkg::CTL_A_ENABLE]};
   // the clock enable bit masks the stall bits in every mode
   assign stall[0] = timer_control[gtu_pkg::CTL_A_STALL] && !timer_control[gtu_pkg::CTL_CLOCK_EN];
   assign stall[1] = timer_control[gtu_pkg::CTL_B_STALL] && !timer_control[gtu_pkg::CTL_CLOCK_EN];
   assign rtc_hold = stall[0] || stall[1];

   // joined timer runs from the lower enable and lower stall only
   assign run32 = is32 && !is_rtc && enable[0] && !stall[0];
   assign hit32 = run32 && (count32 == 32'h00000000);

   // clock steps once per divided second, upward
   assign rtc_step = is_rtc && enable[0] && !rtc_hold && sec_tick;
   assign rtc_hit = rtc_step && (count32 == match_value);
   assign rtc_first = wr && (PADDR == gtu_pkg::OFS_CONFIG)
      && (PWDATA[2:0] == gtu_pkg::CFG_RTC32) && !is_rtc;

   // ------------------------------------------------------------
   // pin synchronisers: even pin feeds timer a and the clock,
   // odd pin feeds timer b in split mode only
   // ------------------------------------------------------------
   gtu_pin_sync u_even_sync (
      .clk(SYS_CLK),
      .rst_n(NRST),
      .pin(CCP_EVEN),
      .level(),
      .rise(pin_rise[0])
   );

   gtu_pin_sync u_odd_sync (
      .clk(SYS_CLK),
      .rst_n(NRST),
      .pin(CCP_ODD),
      .level(),
      .rise(pin_rise[1])
   );

   // ------------------------------------------------------------
   // per-half run, step and zero detection in split mode
   // ------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_half
         assign run16[gi] = !is32 && enable[gi] && !stall[gi];
         // edge count mode steps on its own pin; timed modes step every clock
         assign step16[gi] = run16[gi]
            && ((mode_field[gi] == gtu_pkg::MODE_EDGE_COUNT) ? pin_rise[gi] : 1'b1);
         assign hit16[gi] = step16[gi] && (count_val[gi] == 16'h0000);
         assign one_shot_done[gi] = (mode_field[gi] == gtu_pkg::MODE_ONE_SHOT)
            && ((gi == 0) ? (hit16[gi] || hit32) : hit16[gi]);
      end
   endgenerate

   // ------------------------------------------------------------
   // 1 hz divider: counts filtered pin rises while in clock mode
   // ------------------------------------------------------------
   assign sec_tick = is_rtc && pin_rise[0] && (div_count == DIV_LAST);

   // divider restarts whenever clock mode is left
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         div_count <= 16'h0000;
      end else if (!is_rtc) begin
         div_count <= 16'h0000;
      end else if (pin_rise[0]) begin
         div_count <= sec_tick ? 16'h0000 : div_count + 16'h0001;
      end
   end

   // ------------------------------------------------------------
   // counter next value
   // ------------------------------------------------------------
   always_comb begin
      next_count32 = count32;
      if (rtc_first) begin
         next_count32 = gtu_pkg::RTC_START;
      end else if (is32) begin
         if (wr_load_a) begin
            next_count32 = PWDATA;
         end else if (is_rtc) begin
            if (rtc_step) begin
               next_count32 = rtc_hit ? gtu_pkg::RTC_ROLL : count32 + 32'h00000001;
            end
         end else if (hit32) begin
            next_count32 = load32;
         end else if (run32) begin
            next_count32 = count32 - 32'h00000001;
         end
      end else begin
         for (int i = 0; i < 2; i++) begin
            if ((i == 0) ? wr_load_a : wr_load_b) begin
               next_count32[i*16 +: 16] = PWDATA[15:0];
            end else if (hit16[i]) begin
               next_count32[i*16 +: 16] = interval_load[i];
            end else if (step16[i]) begin
               next_count32[i*16 +: 16] = count_val[i] - 16'h0001;
            end
         end
      end
   end

   // counter halves; a stall holds its own counter (both halves when joined, though only the lower stall in timer32), but a load write still lands
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         count_val[0] <= gtu_pkg::COUNT_RESET;
         count_val[1] <= gtu_pkg::COUNT_RESET;
      end else begin
         count_val[0] <= next_count32[15:0];
         count_val[1] <= next_count32[31:16];
      end
   end

   // ------------------------------------------------------------
   // configuration, load, match and prescale registers
   // ------------------------------------------------------------
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         timer_config <= gtu_pkg::CFG_TIMER32;
         mode_field[0] <= 2'h0;
         mode_field[1] <= 2'h0;
         interval_load[0] <= gtu_pkg::LOAD_RESET;
         interval_load[1] <= gtu_pkg::LOAD_RESET;
         match_value <= gtu_pkg::MATCH_RESET;
         prescale[0] <= gtu_pkg::PRESCALE_RESET;
         prescale[1] <= gtu_pkg::PRESCALE_RESET;
      end else if (wr) begin
         case (PADDR)
            gtu_pkg::OFS_CONFIG: timer_config <= PWDATA[2:0];
            gtu_pkg::OFS_A_MODE: mode_field[0] <= PWDATA[1:0];
            gtu_pkg::OFS_B_MODE: mode_field[1] <= PWDATA[1:0];
            gtu_pkg::OFS_A_LOAD: begin
               interval_load[0] <= PWDATA[15:0];
               // joined write also fills the upper half
               if (is32) begin
                  interval_load[1] <= PWDATA[31:16];
               end
            end
            gtu_pkg::OFS_B_LOAD: interval_load[1] <= PWDATA[15:0];
            gtu_pkg::OFS_A_MATCH: match_value <= PWDATA;
            gtu_pkg::OFS_A_PRESCALE: prescale[0] <= PWDATA[7:0];
            gtu_pkg::OFS_B_PRESCALE: prescale[1] <= PWDATA[7:0];
            default: ;
         endcase
      end
   end

   // ------------------------------------------------------------
   // control: software writes, hardware clears enable on one-shot end
   // ------------------------------------------------------------
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         timer_control <= 16'h0000;
      end else if (wr && (PADDR == gtu_pkg::OFS_CONTROL)) begin
         timer_control <= PWDATA[15:0] & gtu_pkg::CTL_MASK;
      end else begin
         if (one_shot_done[0]) begin
            timer_control[gtu_pkg::CTL_A_ENABLE] <= 1'b0;
         end
         if (one_shot_done[1]) begin
            timer_control[gtu_pkg::CTL_B_ENABLE] <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // status flags: set beats a clear in the same cycle
   // ------------------------------------------------------------
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         raw_status <= 9'h000;
      end else begin
         raw_status[gtu_pkg::INT_A_TIMEOUT] <= (hit32 || hit16[0])
            || (raw_status[gtu_pkg::INT_A_TIMEOUT]
            && !(wr && (PADDR == gtu_pkg::OFS_INT_CLEAR)
            && PWDATA[gtu_pkg::INT_A_TIMEOUT]));
         raw_status[gtu_pkg::INT_B_TIMEOUT] <= hit16[1]
            || (raw_status[gtu_pkg::INT_B_TIMEOUT]
            && !(wr && (PADDR == gtu_pkg::OFS_INT_CLEAR)
            && PWDATA[gtu_pkg::INT_B_TIMEOUT]));
         raw_status[gtu_pkg::INT_CLOCK_MATCH] <= rtc_hit
            || (raw_status[gtu_pkg::INT_CLOCK_MATCH]
            && !(wr && (PADDR == gtu_pkg::OFS_INT_CLEAR)
            && PWDATA[gtu_pkg::INT_CLOCK_MATCH]));
      end
   end

   // mask register and registered interrupt line
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         interrupt_mask <= 9'h000;
         TIMER_IRQ <= 1'b0;
      end else begin
         if (wr && (PADDR == gtu_pkg::OFS_INT_MASK)) begin
            interrupt_mask <= PWDATA[8:0] & gtu_pkg::INT_MASK_BITS;
         end
         TIMER_IRQ <= |masked_status;
      end
   end

   assign masked_status = raw_status & interrupt_mask;

   // ------------------------------------------------------------
   // output triggers: one clock high per zero crossing
   // ------------------------------------------------------------
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         TRIG_A <= 1'b0;
         TRIG_B <= 1'b0;
      end else begin
         TRIG_A <= (hit32 || hit16[0]) && timer_control[gtu_pkg::CTL_A_TRIG_EN];
         TRIG_B <= hit16[1] && timer_control[gtu_pkg::CTL_B_TRIG_EN];
      end
   end

   // ------------------------------------------------------------
   // read mux, captured in the setup cycle
   // ------------------------------------------------------------
   always_comb begin
      next_rdata = 32'h00000000;
      addr_ok = 1'b1;
      case (PADDR)
         gtu_pkg::OFS_CONFIG: next_rdata[2:0] = timer_config;
         gtu_pkg::OFS_A_MODE: next_rdata[1:0] = mode_field[0];
         gtu_pkg::OFS_B_MODE: next_rdata[1:0] = mode_field[1];
         gtu_pkg::OFS_CONTROL: next_rdata[15:0] = timer_control;
         gtu_pkg::OFS_INT_MASK: next_rdata[8:0] = interrupt_mask;
         gtu_pkg::OFS_RAW_STATUS: next_rdata[8:0] = raw_status;
         gtu_pkg::OFS_MASKED_STATUS: next_rdata[8:0] = masked_status;
         gtu_pkg::OFS_INT_CLEAR: next_rdata = 32'h00000000;
         gtu_pkg::OFS_A_LOAD: next_rdata = is32 ? load32 : {16'h0000, interval_load[0]};
         gtu_pkg::OFS_B_LOAD: next_rdata[15:0] = interval_load[1];
         gtu_pkg::OFS_A_MATCH: next_rdata = match_value;
         gtu_pkg::OFS_A_PRESCALE: next_rdata[7:0] = prescale[0];
         gtu_pkg::OFS_B_PRESCALE: next_rdata[7:0] = prescale[1];
         gtu_pkg::OFS_A_COUNT: next_rdata = is32 ? count32 : {16'h0000, count_val[0]};
         gtu_pkg::OFS_B_COUNT: next_rdata[15:0] = count_val[1];
         default: addr_ok = 1'b0;
      endcase
   end

   // holding data from setup keeps it steady through the access phase
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         PRDATA <= 32'h00000000;
      end else if (rd_setup) begin
         PRDATA <= next_rdata;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   property p_trig_one_cycle;
      @(posedge SYS_CLK) disable iff (!NRST)
      $rose(TRIG_A) |=> !TRIG_A;
   endproperty
   a_trig_one_cycle: assert property (p_trig_one_cycle)
      else $error("trigger a stayed high beyond one cycle");

   property p_trig_at_zero;
      @(posedge SYS_CLK) disable iff (!NRST)
      hit32 && timer_control[gtu_pkg::CTL_A_TRIG_EN] |=> TRIG_A;
   endproperty
   a_trig_at_zero: assert property (p_trig_at_zero)
      else $error("trigger a missing after joined zero");

   property p_reload;
      @(posedge SYS_CLK) disable iff (!NRST)
      hit32 && !wr_load_a && !rtc_first |=> count32 == $past(load32);
   endproperty
   a_reload: assert property (p_reload)
      else $error("joined counter did not reload at zero");

   property p_one_shot_stop;
      @(posedge SYS_CLK) disable iff (!NRST)
      hit32 && (mode_field[0] == gtu_pkg::MODE_ONE_SHOT) && !wr
         |=> !timer_control[gtu_pkg::CTL_A_ENABLE] ##1 ($stable(count32) || $past(wr));
   endproperty
   a_one_shot_stop: assert property (p_one_shot_stop)
      else $error("one-shot did not stop after zero");

   property p_count_down;
      @(posedge SYS_CLK) disable iff (!NRST)
      run32 && !hit32 && !wr_load_a && !rtc_first |=> count32 == $past(count32) - 32'h1;
   endproperty
   a_count_down: assert property (p_count_down)
      else $error("joined counter did not step down");

   property p_stall_hold;
      @(posedge SYS_CLK) disable iff (!NRST)
      is32 && !is_rtc && stall[0] && !wr_load_a && !rtc_first |=> $stable(count32);
   endproperty
   a_stall_hold: assert property (p_stall_hold)
      else $error("joined counter moved while stalled");

   property p_timeout_flags;
      @(posedge SYS_CLK) disable iff (!NRST)
      hit32 |=> raw_status[gtu_pkg::INT_A_TIMEOUT]
         ##1 (TIMER_IRQ == $past(interrupt_mask[gtu_pkg::INT_A_TIMEOUT])) || $past(wr);
   endproperty
   a_timeout_flags: assert property (p_timeout_flags)
      else $error("time-out flag or interrupt wrong after zero");

   property p_rtc_roll;
      @(posedge SYS_CLK) disable iff (!NRST)
      rtc_hit && !wr_load_a |=> (count32 == 32'h0) && raw_status[gtu_pkg::INT_CLOCK_MATCH];
   endproperty
   a_rtc_roll: assert property (p_rtc_roll)
      else $error("clock match did not roll to zero and flag");

   property p_rtc_up;
      @(posedge SYS_CLK) disable iff (!NRST)
      rtc_step && !rtc_hit && !wr_load_a |=> count32 == $past(count32) + 32'h1;
   endproperty
   a_rtc_up: assert property (p_rtc_up)
      else $error("clock counter did not step up");

   property p_rtc_first;
      @(posedge SYS_CLK) disable iff (!NRST)
      rtc_first |=> is_rtc && (count32 == gtu_pkg::RTC_START);
   endproperty
   a_rtc_first: assert property (p_rtc_first)
      else $error("clock selection did not load one");

   property p_read_joined;
      @(posedge SYS_CLK) disable iff (!NRST)
      rd_setup && is32 && (PADDR == gtu_pkg::OFS_A_COUNT)
         |=> PRDATA == {$past(count_val[1]), $past(count_val[0])};
   endproperty
   a_read_joined: assert property (p_read_joined)
      else $error("joined count read has wrong word order");

endmodule
